// File: verilog/iss_top.sv
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module iss_top
  import iss_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [ISS_ADDR_W-1:0] reg_addr,
  input wire logic [ISS_DATA_W-1:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ISS_DATA_W-1:0] reg_rd_data,
  input wire logic pwm_pair_zero_source_pin,
  input wire logic timer_a_ch_zero_out,
  input wire logic timer_a_ch_one_out,
  input wire logic timer_a_ch_one_pin,
  input wire logic timer_a_ch_two_pin,
  input wire logic timer_a_ch_three_pin,
  input wire logic comparator_a_out,
  input wire logic comparator_b_out,
  input wire logic interval_timer_zero_out,
  input wire logic pwm_reload_sync,
  input wire logic [ISS_SAMPLE_W-1:0] converter_slot_zero_result,
  input wire logic [ISS_SAMPLE_W-1:0] sample_zero_high_limit,
  input wire logic [ISS_SAMPLE_W-1:0] sample_zero_low_limit,
  output logic pwm_zero_level,
  output logic pwm_one_level,
  output logic converter_zero_sync,
  output logic converter_one_sync,
  output logic timer_a_in1,
  output logic timer_a_in2,
  output logic timer_a_in3
);

  // ---------------------------------------------------------------
  // shared decode
  // ---------------------------------------------------------------

  // one sync select field to its source; both converters share it
  function automatic logic sync_mux(
    input logic [2:0] sel,
    input logic interval_timer,
    input logic reload_sync,
    input logic timer_zero,
    input logic timer_one
  );
    logic result;
    result = 1'b0;
    case (sel)
      ISS_SYNC_INTERVAL_TIMER: result = interval_timer;
      ISS_SYNC_PWM_RELOAD: result = reload_sync;
      ISS_SYNC_TIMER_ZERO: result = timer_zero;
      ISS_SYNC_TIMER_ONE: result = timer_one;
      default: result = 1'b0;
    endcase
    return result;
  endfunction

  // ---------------------------------------------------------------
  // select registers
  // ---------------------------------------------------------------
  logic [2:0] pwm_pair_zero_source_sel_reg;
  logic [2:0] pwm_pair_zero_source_sel_next;
  logic [2:0] converter_one_sync_sel_reg;
  logic [2:0] converter_one_sync_sel_next;
  logic [2:0] converter_zero_sync_sel_reg;
  logic [2:0] converter_zero_sync_sel_next;
  logic timer_in1_source_sel_reg;
  logic timer_in1_source_sel_next;
  logic timer_in2_source_sel_reg;
  logic timer_in2_source_sel_next;
  logic timer_in3_source_sel_reg;
  logic timer_in3_source_sel_next;

  // write decode; reserved bits are never stored, so they read zero
  // even if software breaks its promise to write them as zero
  always_comb begin
    pwm_pair_zero_source_sel_next = pwm_pair_zero_source_sel_reg;
    converter_one_sync_sel_next = converter_one_sync_sel_reg;
    converter_zero_sync_sel_next = converter_zero_sync_sel_reg;
    timer_in1_source_sel_next = timer_in1_source_sel_reg;
    timer_in2_source_sel_next = timer_in2_source_sel_reg;
    timer_in3_source_sel_next = timer_in3_source_sel_reg;
    if (reg_wr) begin
      if (reg_addr == ISS_PWM_SOURCE_SELECT_OFF) begin
        pwm_pair_zero_source_sel_next =
          reg_wr_data[ISS_PWM_ZERO_LSB +: 3];
      end else if (reg_addr == ISS_CONVERTER_SYNC_SOURCE_SELECT_OFF) begin
        converter_one_sync_sel_next = reg_wr_data[ISS_CONV_ONE_LSB +: 3];
        converter_zero_sync_sel_next = reg_wr_data[ISS_CONV_ZERO_LSB +: 3];
      end else if (reg_addr == ISS_TIMER_A_INPUT_SOURCE_SELECT_OFF) begin
        timer_in1_source_sel_next = reg_wr_data[ISS_TIMER_IN1_BIT];
        timer_in2_source_sel_next = reg_wr_data[ISS_TIMER_IN2_BIT];
        timer_in3_source_sel_next = reg_wr_data[ISS_TIMER_IN3_BIT];
      end
    end
  end

  // all fields come out of reset at code zero: pin or interval timer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwm_pair_zero_source_sel_reg <= ISS_SEL3_RESET;
      converter_one_sync_sel_reg <= ISS_SEL3_RESET;
      converter_zero_sync_sel_reg <= ISS_SEL3_RESET;
      timer_in1_source_sel_reg <= ISS_SEL1_RESET;
      timer_in2_source_sel_reg <= ISS_SEL1_RESET;
      timer_in3_source_sel_reg <= ISS_SEL1_RESET;
    end else if (clk_en) begin
      pwm_pair_zero_source_sel_reg <= pwm_pair_zero_source_sel_next;
      converter_one_sync_sel_reg <= converter_one_sync_sel_next;
      converter_zero_sync_sel_reg <= converter_zero_sync_sel_next;
      timer_in1_source_sel_reg <= timer_in1_source_sel_next;
      timer_in2_source_sel_reg <= timer_in2_source_sel_next;
      timer_in3_source_sel_reg <= timer_in3_source_sel_next;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  logic [ISS_DATA_W-1:0] rd_data_reg;
  logic [ISS_DATA_W-1:0] rd_data_next;

  // data stand for exactly the cycle after the strobe; otherwise zero
  always_comb begin
    rd_data_next = ISS_RD_DATA_RESET;
    if (reg_rd) begin
      if (reg_addr == ISS_PWM_SOURCE_SELECT_OFF) begin
        rd_data_next[ISS_PWM_ZERO_LSB +: 3] = pwm_pair_zero_source_sel_reg;
      end else if (reg_addr == ISS_CONVERTER_SYNC_SOURCE_SELECT_OFF) begin
        rd_data_next[ISS_CONV_ONE_LSB +: 3] = converter_one_sync_sel_reg;
        rd_data_next[ISS_CONV_ZERO_LSB +: 3] = converter_zero_sync_sel_reg;
      end else if (reg_addr == ISS_TIMER_A_INPUT_SOURCE_SELECT_OFF) begin
        rd_data_next[ISS_TIMER_IN1_BIT] = timer_in1_source_sel_reg;
        rd_data_next[ISS_TIMER_IN2_BIT] = timer_in2_source_sel_reg;
        rd_data_next[ISS_TIMER_IN3_BIT] = timer_in3_source_sel_reg;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data_reg <= ISS_RD_DATA_RESET;
    end else if (clk_en) begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign reg_rd_data = rd_data_reg;

  // ---------------------------------------------------------------
  // pwm pair-zero source
  // ---------------------------------------------------------------
  logic limit_mode;
  logic limit_zero;
  logic limit_one;
  logic pair_source;
  logic pair_valid;

  assign limit_mode = pwm_pair_zero_source_sel_reg == ISS_PSRC_LIMIT;

  // the window compare keeps its own held state for the in-range case
  iss_limit_cmp u_limit_cmp (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .enable(limit_mode),
    .sample(converter_slot_zero_result),
    .high_limit(sample_zero_high_limit),
    .low_limit(sample_zero_low_limit),
    .pwm_zero_level(limit_zero),
    .pwm_one_level(limit_one)
  );

  // single-wire sources; reserved codes give an idle low pair
  always_comb begin
    pair_source = 1'b0;
    pair_valid = 1'b1;
    case (pwm_pair_zero_source_sel_reg)
      ISS_PSRC_PIN: pair_source = pwm_pair_zero_source_pin;
      ISS_PSRC_TIMER_ZERO: pair_source = timer_a_ch_zero_out;
      ISS_PSRC_CMP_A: pair_source = comparator_a_out;
      ISS_PSRC_CMP_B: pair_source = comparator_b_out;
      ISS_PSRC_LIMIT: pair_source = limit_zero;
      default: pair_valid = 1'b0;
    endcase
  end

  // outputs stay combinational so the pair sees no extra delay,
  // at the cost of not being flop-driven at the block edge
  always_comb begin
    if (!pair_valid) begin
      pwm_zero_level = 1'b0;
      pwm_one_level = 1'b0;
    end else if (limit_mode) begin
      pwm_zero_level = limit_zero;
      pwm_one_level = limit_one;
    end else begin
      pwm_zero_level = pair_source;
      pwm_one_level = ~pair_source;
    end
  end

  // ---------------------------------------------------------------
  // converter sync inputs
  // ---------------------------------------------------------------

  // both converters decode with one function so the codes cannot drift
  always_comb begin
    converter_one_sync = sync_mux(converter_one_sync_sel_reg,
      interval_timer_zero_out, pwm_reload_sync,
      timer_a_ch_zero_out, timer_a_ch_one_out);
    converter_zero_sync = sync_mux(converter_zero_sync_sel_reg,
      interval_timer_zero_out, pwm_reload_sync,
      timer_a_ch_zero_out, timer_a_ch_one_out);
  end

  // ---------------------------------------------------------------
  // timer A inputs
  // ---------------------------------------------------------------

  // reload sync is only seen by the timer when both run at one rate;
  // that clocking is up to software and not checked here
  always_comb begin
    timer_a_in3 = timer_in3_source_sel_reg ? pwm_reload_sync
                                           : timer_a_ch_three_pin;
    timer_a_in2 = timer_in2_source_sel_reg ? comparator_b_out
                                           : timer_a_ch_two_pin;
    timer_a_in1 = timer_in1_source_sel_reg ? comparator_a_out
                                           : timer_a_ch_one_pin;
  end

endmodule

`default_nettype wire

// File: shared/iss_pkg.sv
`default_nettype none
package iss_pkg;

  // ---------------------------------------------------------------
  // register bus geometry
  // ---------------------------------------------------------------
  localparam int ISS_ADDR_W = 8;
  localparam int ISS_DATA_W = 16;
  localparam int ISS_SAMPLE_W = 16;

  // ---------------------------------------------------------------
  // register offsets (word addresses on the plain port)
  // ---------------------------------------------------------------
  localparam logic [7:0] ISS_PWM_SOURCE_SELECT_OFF = 8'h18;
  localparam logic [7:0] ISS_CONVERTER_SYNC_SOURCE_SELECT_OFF = 8'h19;
  localparam logic [7:0] ISS_TIMER_A_INPUT_SOURCE_SELECT_OFF = 8'h1A;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ISS_PWM_ZERO_LSB = 0;
  localparam int ISS_CONV_ZERO_LSB = 0;
  localparam int ISS_CONV_ONE_LSB = 4;
  localparam int ISS_TIMER_IN1_BIT = 4;
  localparam int ISS_TIMER_IN2_BIT = 8;
  localparam int ISS_TIMER_IN3_BIT = 12;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [2:0] ISS_SEL3_RESET = 3'h0;
  localparam logic ISS_SEL1_RESET = 1'h0;
  localparam logic [15:0] ISS_RD_DATA_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // pwm pair-zero source codes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ISS_PSRC_PIN = 3'h0,
    ISS_PSRC_TIMER_ZERO = 3'h1,
    ISS_PSRC_LIMIT = 3'h2,
    ISS_PSRC_CMP_A = 3'h3,
    ISS_PSRC_CMP_B = 3'h4
  } iss_psrc_code_t;

  // ---------------------------------------------------------------
  // converter sync source codes, shared by both converters
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ISS_SYNC_INTERVAL_TIMER = 3'h0,
    ISS_SYNC_PWM_RELOAD = 3'h3,
    ISS_SYNC_TIMER_ZERO = 3'h4,
    ISS_SYNC_TIMER_ONE = 3'h5
  } iss_sync_code_t;

endpackage
`default_nettype wire

// File: verilog/iss_limit_cmp.sv
`timescale 1ns/1ps
`default_nettype none

// window compare of converter slot zero against its limits
module iss_limit_cmp
  import iss_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic enable,
  input wire logic [ISS_SAMPLE_W-1:0] sample,
  input wire logic [ISS_SAMPLE_W-1:0] high_limit,
  input wire logic [ISS_SAMPLE_W-1:0] low_limit,
  output logic pwm_zero_level,
  output logic pwm_one_level
);

  // ---------------------------------------------------------------
  // comparison and held decision
  // ---------------------------------------------------------------
  logic above;
  logic below;
  logic hold_zero_reg;
  logic hold_one_reg;
  logic hold_zero_next;
  logic hold_one_next;

  // inside the window the pair keeps its last forced state
  always_comb begin
    above = sample > high_limit;
    below = sample < low_limit;
    hold_zero_next = hold_zero_reg;
    hold_one_next = hold_one_reg;
    if (enable && above) begin
      hold_zero_next = 1'b0;
      hold_one_next = 1'b1;
    end else if (enable && below) begin
      hold_zero_next = 1'b1;
      hold_one_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_zero_reg <= 1'b0;
      hold_one_reg <= 1'b0;
    end else if (clk_en) begin
      hold_zero_reg <= hold_zero_next;
      hold_one_reg <= hold_one_next;
    end
  end

  // outputs follow the compare at once, no added cycle
  always_comb begin
    pwm_zero_level = hold_zero_next;
    pwm_one_level = hold_one_next;
  end

endmodule

`default_nettype wire

// File: test/iss_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ----------
// mux checks seen at the top ports
// ----------
module iss_top_asserts
  import iss_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ISS_ADDR_W-1:0] reg_addr,
  input wire logic [ISS_DATA_W-1:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic pwm_pair_zero_source_pin,
  input wire logic timer_a_ch_zero_out,
  input wire logic timer_a_ch_three_pin,
  input wire logic comparator_a_out,
  input wire logic comparator_b_out,
  input wire logic interval_timer_zero_out,
  input wire logic pwm_reload_sync,
  input wire logic [ISS_SAMPLE_W-1:0] converter_slot_zero_result,
  input wire logic [ISS_SAMPLE_W-1:0] sample_zero_high_limit,
  input wire logic [ISS_SAMPLE_W-1:0] sample_zero_low_limit,
  input wire logic pwm_zero_level,
  input wire logic pwm_one_level,
  input wire logic converter_one_sync,
  input wire logic timer_a_in3
);
  logic [2:0] ps_reg, ps_next;
  logic t3_reg, t3_next;
  logic src;
  // shadow selects; a write lands at its strobe edge, like the real store
  always_comb begin
    ps_next = ps_reg;
    t3_next = t3_reg;
    if (reg_wr && reg_addr == ISS_PWM_SOURCE_SELECT_OFF) ps_next = reg_wr_data[2:0];
    if (reg_wr && reg_addr == ISS_TIMER_A_INPUT_SOURCE_SELECT_OFF) t3_next = reg_wr_data[12];
  end
  always_ff @(posedge clk) begin
    ps_reg <= rst_n ? ps_next : 3'h0;
    t3_reg <= rst_n ? t3_next : 1'b0;
  end
  // pass-through source; only read for codes that pass a signal
  always_comb begin
    case (ps_reg)
      3'h0: src = pwm_pair_zero_source_pin;
      3'h1: src = timer_a_ch_zero_out;
      3'h3: src = comparator_a_out;
      default: src = comparator_b_out;
    endcase
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_limit; ps_reg == 3'h2; endsequence
  sequence s_sync_wr; reg_wr && reg_addr == ISS_CONVERTER_SYNC_SOURCE_SELECT_OFF; endsequence
  property p_dflt;
    $rose(rst_n) |-> pwm_zero_level == pwm_pair_zero_source_pin
      && converter_one_sync == interval_timer_zero_out;
  endproperty
  a_dflt: assert property (p_dflt) else $error("default routing wrong");
  property p_src; ps_reg inside {3'h0, 3'h1, 3'h3, 3'h4} |-> pwm_zero_level == src; endproperty
  a_src: assert property (p_src) else $error("pair source wrong");
  property p_hi;
    s_limit ##0 (converter_slot_zero_result > sample_zero_high_limit)
      |-> !pwm_zero_level && pwm_one_level;
  endproperty
  a_hi: assert property (p_hi) else $error("above limit drive wrong");
  property p_lo;
    s_limit ##0 (converter_slot_zero_result < sample_zero_low_limit)
      |-> pwm_zero_level && !pwm_one_level;
  endproperty
  a_lo: assert property (p_lo) else $error("below limit drive wrong");
  property p_rsv; ps_reg > 3'h4 |-> !pwm_zero_level && !pwm_one_level; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved code not low");
  property p_tin3; timer_a_in3 == (t3_reg ? pwm_reload_sync : timer_a_ch_three_pin); endproperty
  a_tin3: assert property (p_tin3) else $error("timer input 3 wrong");
  property p_sync_rel;
    s_sync_wr ##0 (reg_wr_data[6:4] == 3'h3) |=> converter_one_sync == pwm_reload_sync;
  endproperty
  a_sync_rel: assert property (p_sync_rel) else $error("sync reload wrong");
  property p_sync_tmr;
    s_sync_wr ##0 (reg_wr_data[6:4] == 3'h4) |=> converter_one_sync == timer_a_ch_zero_out;
  endproperty
  a_sync_tmr: assert property (p_sync_tmr) else $error("sync timer wrong");
endmodule
`default_nettype wire

// File: test/iss_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------
// peripheral side sources
// ----------
module iss_periph_model (
  input wire logic clk,
  input wire logic [9:0] stim,
  output logic [9:0] src_reg
);
  logic [9:0] src_next;
  // pwm and timers share this clock, so levels move only after an edge
  always_comb src_next = stim;
  // each input has one driver, never two pins fighting; the sources hold
  // no enable or setup state, so a select move never catches one mid-run
  always_ff @(posedge clk) src_reg <= src_next;
endmodule
`default_nettype wire

// File: test/iss_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module iss_top_tb_top
  import iss_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, hz = 1'b0, ho = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000, smp = 16'h0000, hi = 16'h0000, lo = 16'h0000, rdata;
  logic [9:0] stim = 10'h000, src;
  logic pz, po, cz, co, t1, t2, t3;
  logic [31:0] rs = 32'h88497533;
  logic [2:0] psel = 3'h0, c0 = 3'h0, c1 = 3'h0, tb = 3'h0;
  logic [7:0] ofs [4] = '{8'h18, 8'h19, 8'h1A, 8'h1B};
  int failures = 0, tests_run = 0, cyc = 0;
  iss_periph_model i_src (.clk(clk), .stim(stim), .src_reg(src));
  iss_top i_dut (
    .clk(clk), .rst_n(rst_n), .clk_en(1'b1), .reg_addr(addr), .reg_wr_data(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rd_data(rdata), .pwm_pair_zero_source_pin(src[0]),
    .timer_a_ch_zero_out(src[1]), .timer_a_ch_one_out(src[2]), .timer_a_ch_one_pin(src[3]),
    .timer_a_ch_two_pin(src[4]), .timer_a_ch_three_pin(src[5]), .comparator_a_out(src[6]),
    .comparator_b_out(src[7]), .interval_timer_zero_out(src[8]), .pwm_reload_sync(src[9]),
    .converter_slot_zero_result(smp), .sample_zero_high_limit(hi), .sample_zero_low_limit(lo),
    .pwm_zero_level(pz), .pwm_one_level(po), .converter_zero_sync(cz),
    .converter_one_sync(co), .timer_a_in1(t1), .timer_a_in2(t2), .timer_a_in3(t3)
  );
  initial forever #50 clk = ~clk;
  // ----------
  // helpers
  // ----------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic syn(input logic [2:0] c);
    return (c == 3'h0) ? src[8] : (c == 3'h3) ? src[9] : (c == 3'h4) ? src[1]
      : (c == 3'h5) ? src[2] : 1'b0;
  endfunction
  function automatic logic [15:0] rexp(input logic [7:0] a);
    if (a == ISS_PWM_SOURCE_SELECT_OFF) return {13'h0000, psel};
    if (a == ISS_CONVERTER_SYNC_SOURCE_SELECT_OFF) return {9'h000, c1, 1'b0, c0};
    if (a == ISS_TIMER_A_INPUT_SOURCE_SELECT_OFF)
      return {3'h0, tb[2], 3'h0, tb[1], 3'h0, tb[0], 4'h0};
    return 16'h0000;
  endfunction
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // a gap cycle follows each strobe so no signal is driven twice in one step
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    if (a == ISS_PWM_SOURCE_SELECT_OFF) psel = d[2:0];
    if (a == ISS_CONVERTER_SYNC_SOURCE_SELECT_OFF) {c1, c0} = {d[6:4], d[2:0]};
    if (a == ISS_TIMER_A_INPUT_SOURCE_SELECT_OFF) tb = {d[12], d[8], d[4]};
  endtask
  task automatic rreg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("read_data", rdata, e);
  endtask
  task automatic summarize();
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // random sources and samples, launched just after each edge
  always @(posedge clk) begin
    rs = xs(rs);
    stim <= rs[9:0];
    smp <= rs[31:16];
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      failures++;
      summarize();
    end
  end
  // reference model, checked mid-cycle once edge updates have landed
  always @(negedge clk) begin
    logic s, ez, eo;
    if (rst_n) begin
      s = (psel == 3'h0) ? src[0] : (psel == 3'h1) ? src[1] : (psel == 3'h3) ? src[6] : src[7];
      ez = (psel > 3'h4) ? 1'b0 : s;
      eo = (psel > 3'h4) ? 1'b0 : !s;
      if (psel == 3'h2) begin
        if (smp > hi) {hz, ho} = 2'b01;
        else if (smp < lo) {hz, ho} = 2'b10;
        {ez, eo} = {hz, ho};
      end
      chk("pwm_zero", pz, ez);
      chk("pwm_one", po, eo);
      chk("sync_zero", cz, syn(c0));
      chk("sync_one", co, syn(c1));
      chk("timer_in1", t1, tb[0] ? src[6] : src[3]);
      chk("timer_in2", t2, tb[1] ? src[7] : src[4]);
      chk("timer_in3", t3, tb[2] ? src[9] : src[5]);
    end
  end
  // ----------
  // main sequence
  // ----------
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    lo <= 16'h4000;
    hi <= 16'hC000;
    foreach (ofs[i]) rreg(ofs[i], 16'h0000);
    for (int k = 0; k < 8; k++) begin
      wreg(ISS_PWM_SOURCE_SELECT_OFF, {13'h0000, 3'(k)});
      wreg(ISS_CONVERTER_SYNC_SOURCE_SELECT_OFF, {9'h000, 3'(k), 1'b0, 3'(7 - k)});
      wreg(ISS_TIMER_A_INPUT_SOURCE_SELECT_OFF, rs[15:0] & 16'h1110);
      wreg(8'h1B, 16'hFFFF);
      foreach (ofs[i]) rreg(ofs[i], rexp(ofs[i]));
      repeat (24) @(posedge clk);
    end
    // second reset while non-default selects are loaded
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    {psel, c0, c1, tb, hz, ho} = '0;
    foreach (ofs[i]) rreg(ofs[i], 16'h0000);
    summarize();
  end
endmodule
bind iss_top iss_top_asserts u_chk (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr),
  .pwm_pair_zero_source_pin(pwm_pair_zero_source_pin), .timer_a_ch_zero_out(timer_a_ch_zero_out),
  .timer_a_ch_three_pin(timer_a_ch_three_pin), .comparator_a_out(comparator_a_out),
  .comparator_b_out(comparator_b_out), .interval_timer_zero_out(interval_timer_zero_out),
  .pwm_reload_sync(pwm_reload_sync), .converter_slot_zero_result(converter_slot_zero_result),
  .sample_zero_high_limit(sample_zero_high_limit), .sample_zero_low_limit(sample_zero_low_limit),
  .pwm_zero_level(pwm_zero_level), .pwm_one_level(pwm_one_level),
  .converter_one_sync(converter_one_sync), .timer_a_in3(timer_a_in3)
);
`default_nettype wire
